//--- design/ucr_clkgen.sv
// Purpose: card clock generator for the user-card slot
// Assumes: input clock already synchronised, well below half the system clock
// Notes: divider counts input edges, so odd ratios keep their period
`timescale 1ns/1ns
module ucr_clkgen
   import ucr_pkg::*;
(
   input wire logic clock_i,  // system clock
   input wire logic reset_i,  // synchronous reset, active high
   ucr_clk_if.gen cif         // clock controls and card clock
);
   logic in_prev_q;
   logic [2:0] edge_cnt_q;
   logic div_clk_q;
   logic [INT_CNT_W-1:0] int_cnt_q;
   logic int_clk_q;
   logic card_clk_q;
   logic in_edge;
   logic [2:0] ratio;
   logic next_clk;

   // input half periods per output half period
   function automatic logic [2:0] div_ratio(input logic [2:0] code);
      unique case (code)
         3'h0: div_ratio = 3'h1;
         3'h1: div_ratio = 3'h2;
         3'h2: div_ratio = 3'h4;
         3'h3: div_ratio = 3'h5;
         default: div_ratio = 3'h0; // codes 100..111 mean eight, counter wraps
      endcase
   endfunction

   assign in_edge = cif.in_clk ^ in_prev_q;
   assign ratio = div_ratio(cif.div_sel);

   // divided clock: toggle after ratio input edges
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         in_prev_q <= 1'b0;
         edge_cnt_q <= 3'h0;
         div_clk_q <= 1'b0;
      end else begin
         in_prev_q <= cif.in_clk;
         if (in_edge) begin
            if (edge_cnt_q + 3'h1 == ratio) begin
               edge_cnt_q <= 3'h0;
               div_clk_q <= ~div_clk_q;
            end else begin
               edge_cnt_q <= edge_cnt_q + 3'h1;
            end
         end
      end
   end

   // free running internal clock near 1.2 MHz
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         int_cnt_q <= '0;
         int_clk_q <= 1'b0;
      end else if (int_cnt_q == INT_CNT_W'(INT_HALF_CYC - 1)) begin
         int_cnt_q <= '0;
         int_clk_q <= ~int_clk_q;
      end else begin
         int_cnt_q <= int_cnt_q + INT_CNT_W'(1);
      end
   end

   // source priority per mode
   always_comb begin
      next_clk = 1'b0;
      if (cif.async_mode) begin
         if (cif.int_sel) begin
            next_clk = int_clk_q;
         end else if (cif.force_low) begin
            next_clk = 1'b0;
         end else if (cif.force_high) begin
            next_clk = 1'b1;
         end else if (cif.div_sel == 3'h0) begin
            next_clk = cif.in_clk;
         end else begin
            next_clk = div_clk_q;
         end
      end else if (cif.sync_mode) begin
         if (cif.force_low) begin
            next_clk = 1'b0;
         end else if (cif.clk_en_sync) begin
            next_clk = cif.in_clk;
         end else begin
            next_clk = cif.force_high;
         end
      end
   end

   // registered card clock, idle low when the slot is off
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         card_clk_q <= 1'b0;
      end else begin
         card_clk_q <= next_clk;
      end
   end

   assign cif.card_clk = card_clk_q;
   assign cif.int_active = cif.async_mode & cif.int_sel;
endmodule

//--- design/ucr_slot_regs.sv
// Purpose: user-card slot status, settings and clock registers
// Assumes: byte register port fed by the host serial engine, one clock
// Notes: sequencer and analog events arrive as same-clock pulses
//
// What this block does
// - status bit 7 shows slot active
// - bit 6 sticky early answer, read clears
// - bit 5 sticky missing answer, read clears
// - bit 4 sticky overcurrent, read clears
// - bit 3 shows internal clock mode
// - bit 2 sticky insertion change, read clears
// - bit 1 shows card present
// - bit 0 sticky supply ramp fault, read clears
// - settings 7:6 select supply voltage, reset 01
// - settings bit 5 routes host io to card
// - settings bit 3 starts warm reset outside sync and manual modes, self-clears
// - settings bit 2 picks which presence pin level means card present
// - settings bit 0 starts activation or deactivation outside sync and manual modes
// - clock bit 7 selects internal clock async
// - clock bit 6 holds card clock low, except async with bit 7 set
// - clock bit 5 holds card clock high when async without bits 7 and 6, or sync without bit 6 and enable
// - clock 4:2 divides input clock async
// - sync with enable passes input clock unless bit 6 is set
`timescale 1ns/1ns
module ucr_slot_regs
   import ucr_pkg::*;
(
   input wire logic clock_i,                  // system clock
   input wire logic reset_i,                  // synchronous reset, active high
   input wire logic [7:0] reg_addr_i,         // register index
   input wire logic reg_wr_i,                 // write strobe, one cycle
   input wire logic reg_rd_i,                 // read strobe, one cycle
   input wire logic [7:0] reg_wdata_i,        // write data
   output logic [7:0] reg_rdata_o,            // read data, valid after strobe
   input wire logic slot_active_i,            // supply ramped and stable
   input wire logic answer_early_i,           // early answer pulse
   input wire logic answer_missing_i,         // missing answer pulse
   input wire logic overcurrent_i,            // overcurrent pulse
   input wire logic supply_ramp_fault_i,      // supply ramp fault pulse
   input wire logic auto_deactivate_i,        // automatic deactivation pulse
   input wire logic warm_reset_started_i,     // sequencer took the warm reset
   input wire logic sync_mode_i,              // synchronous type 1 or 2 mode
   input wire logic manual_mode_i,            // manual operating mode
   input wire logic clk_enable_sync_i,        // synchronous clock enable setting
   input wire logic presence_input_i,         // card presence pin
   input wire logic input_clock_i,            // input clock pin
   input wire logic host_io_line_i,           // host io pin level
   output logic host_io_line_o,               // host io drive value
   output logic host_io_line_oe_o,            // host io drive enable
   input wire logic card_io_line_i,           // card io pin level
   output logic card_io_line_o,               // card io drive value
   output logic card_io_line_oe_o,            // card io drive enable
   output logic [1:0] supply_voltage_select_o,// supply code to the regulator
   output logic async_activation_o,           // high: activate, low: deactivate
   output logic warm_reset_request_o,         // warm reset pending
   output logic slot_interrupt_summary_o,     // any event flag pending
   output logic card_clock_output_o           // card clock pin
);
   ucr_clk_if cif ();

   logic presence_input_m_q, presence_input_s_q, presence_input_prev_q;
   logic clk_m_q, clk_s_q;
   logic hio_m_q, hio_s_q, cio_m_q, cio_s_q;
   logic early_q, mute_q, prot_q, presl_q, vfail_q;
   logic [1:0] vsel_q;
   logic ioen_q, warm_q, pol_q, async_q;
   logic ck_int_q, ck_low_q, ck_high_q;
   logic [2:0] ck_div_q;
   logic [7:0] rdata_q;
   logic [7:0] status;
   logic rd_status, wr_settings, wr_clock;
   logic card_present, presence_input_change, mode_locked;
   ucr_io_e io_st_q;
   logic [1:0] io_hold_q;
   logic io_free;

   // strobe decode
   function automatic logic hit(input logic strobe, input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = strobe & (a == ofs);
   endfunction

   assign rd_status = hit(reg_rd_i, reg_addr_i, OFS_STATUS);
   assign wr_settings = hit(reg_wr_i, reg_addr_i, OFS_SETTINGS);
   assign wr_clock = hit(reg_wr_i, reg_addr_i, OFS_CLOCK);
   assign mode_locked = sync_mode_i | manual_mode_i;

   // pin synchronisers; first stage is read only by the second
   // presence resets to its pulled-up idle level, so reset fakes no change
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         presence_input_m_q <= 1'b1;
         presence_input_s_q <= 1'b1;
         presence_input_prev_q <= 1'b1;
         clk_m_q <= 1'b0;
         clk_s_q <= 1'b0;
      end else begin
         presence_input_m_q <= presence_input_i;
         presence_input_s_q <= presence_input_m_q;
         presence_input_prev_q <= presence_input_s_q;
         clk_m_q <= input_clock_i;
         clk_s_q <= clk_m_q;
      end
   end

   // io pins idle high on an open-drain line
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         hio_m_q <= 1'b1;
         hio_s_q <= 1'b1;
         cio_m_q <= 1'b1;
         cio_s_q <= 1'b1;
      end else begin
         hio_m_q <= host_io_line_i;
         hio_s_q <= hio_m_q;
         cio_m_q <= card_io_line_i;
         cio_s_q <= cio_m_q;
      end
   end

   // polarity picks which pin level means a card is in
   assign card_present = pol_q ? presence_input_s_q : ~presence_input_s_q;
   assign presence_input_change = presence_input_s_q ^ presence_input_prev_q;

   // sticky event flags; a new event beats the read clear
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         early_q <= 1'b0;
         mute_q <= 1'b0;
         prot_q <= 1'b0;
         presl_q <= 1'b0;
         vfail_q <= 1'b0;
      end else begin
         early_q <= answer_early_i | (early_q & ~rd_status);
         mute_q <= answer_missing_i | (mute_q & ~rd_status);
         prot_q <= overcurrent_i | (prot_q & ~rd_status);
         presl_q <= presence_input_change | (presl_q & ~rd_status);
         vfail_q <= supply_ramp_fault_i | (vfail_q & ~rd_status);
      end
   end

   // live status view
   always_comb begin
      status = 8'h00;
      status[ST_ACTIVE] = slot_active_i;
      status[ST_EARLY] = early_q;
      status[ST_MUTE] = mute_q;
      status[ST_PROT] = prot_q;
      status[ST_INTCLK] = cif.int_active;
      status[ST_PRESL] = presl_q;
      status[ST_PRESENCE_INPUT] = card_present;
      status[ST_VCCFAIL] = vfail_q;
   end

   // summary level for the device interrupt register
   assign slot_interrupt_summary_o = early_q | mute_q | prot_q | presl_q | vfail_q;

   // settings register plain fields
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         vsel_q <= RST_VSEL;
         ioen_q <= RST_IOEN;
         pol_q <= 1'b0;
      end else if (wr_settings) begin
         vsel_q <= reg_wdata_i[SET_VSEL_HI:SET_VSEL_LO];
         ioen_q <= reg_wdata_i[SET_IOEN];
         pol_q <= reg_wdata_i[SET_POL];
      end
   end

   // warm reset: held until the sequencer starts it; writes in locked modes drop
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         warm_q <= 1'b0;
      end else if (wr_settings & reg_wdata_i[SET_WARM] & ~mode_locked) begin
         warm_q <= 1'b1;
      end else if (warm_reset_started_i) begin
         warm_q <= 1'b0;
      end
   end

   // activation control; a host write in the same cycle outranks auto clear
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         async_q <= 1'b0;
      end else if (wr_settings & ~mode_locked) begin
         async_q <= reg_wdata_i[SET_ASYNC];
      end else if (auto_deactivate_i) begin
         async_q <= 1'b0;
      end
   end

   assign supply_voltage_select_o = vsel_q;
   assign async_activation_o = async_q;
   assign warm_reset_request_o = warm_q;

   // clock settings register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ck_int_q <= 1'b0;
         ck_low_q <= 1'b0;
         ck_high_q <= 1'b0;
         ck_div_q <= RST_DIV;
      end else if (wr_clock) begin
         ck_int_q <= reg_wdata_i[CK_INT];
         ck_low_q <= reg_wdata_i[CK_LOW];
         ck_high_q <= reg_wdata_i[CK_HIGH];
         ck_div_q <= reg_wdata_i[CK_DIV_HI:CK_DIV_LO];
      end
   end

   // read data captured at the strobe edge, the same edge the flags clear
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_STATUS: rdata_q <= status;
            OFS_SETTINGS: rdata_q <= {vsel_q, ioen_q, 1'b0, warm_q, pol_q, 1'b0, async_q};
            OFS_CLOCK: rdata_q <= {ck_int_q, ck_low_q, ck_high_q, ck_div_q, 2'h0};
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata_o = rdata_q;

   // clock generator controls
   assign cif.async_mode = async_q & ~mode_locked;
   assign cif.sync_mode = sync_mode_i;
   assign cif.clk_en_sync = clk_enable_sync_i;
   assign cif.int_sel = ck_int_q;
   assign cif.force_low = ck_low_q;
   assign cif.force_high = ck_high_q;
   assign cif.div_sel = ck_div_q;
   assign cif.in_clk = clk_s_q;

   ucr_clkgen u_clkgen (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .cif(cif)
   );

   assign card_clock_output_o = cif.card_clk;

   // after a release our own drive still sits in the synchronisers; ignoring
   // both sides meanwhile stops the bridge latching itself low and ping-ponging
   assign io_free = ioen_q & (io_hold_q == 2'h0);

   // open-drain io bridge: first side to pull low owns the line until release
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         io_st_q <= IO_IDLE;
         io_hold_q <= 2'h0;
      end else begin
         if (io_hold_q != 2'h0) begin
            io_hold_q <= io_hold_q - 2'h1;
         end
         unique case (io_st_q)
            IO_IDLE: begin
               if (io_free & ~hio_s_q) begin
                  io_st_q <= IO_HOST;
               end else if (io_free & ~cio_s_q) begin
                  io_st_q <= IO_CARD;
               end
            end
            IO_HOST: begin
               if (hio_s_q | ~ioen_q) begin
                  io_st_q <= IO_IDLE;
                  io_hold_q <= IO_HOLD_CYC;
               end
            end
            IO_CARD: begin
               if (cio_s_q | ~ioen_q) begin
                  io_st_q <= IO_IDLE;
                  io_hold_q <= IO_HOLD_CYC;
               end
            end
            default: io_st_q <= IO_IDLE;
         endcase
      end
   end

   // drive low only toward the side that does not own the line
   assign card_io_line_o = 1'b0;
   assign host_io_line_o = 1'b0;
   assign card_io_line_oe_o = (io_st_q == IO_HOST) & ioen_q;
   assign host_io_line_oe_o = (io_st_q == IO_CARD) & ioen_q;
endmodule

//--- inc/ucr_clk_if.sv
// Purpose: carries card clock controls between the slot top and the generator
// Assumes: one clock domain
// Notes: ctrl side drives settings, gen side returns the card clock
`timescale 1ns/1ns
interface ucr_clk_if;
   logic async_mode;     // async activation running
   logic sync_mode;      // synchronous card mode
   logic clk_en_sync;    // synchronous clock enable setting
   logic int_sel;        // internal clock select
   logic force_low;      // hold card clock low
   logic force_high;     // hold card clock high
   logic [2:0] div_sel;  // divider code
   logic in_clk;         // synchronised input clock level
   logic card_clk;       // generated card clock
   logic int_active;     // internal clock in use
   modport ctrl (output async_mode, sync_mode, clk_en_sync, int_sel, force_low,
                 force_high, div_sel, in_clk, input card_clk, int_active);
   modport gen (input async_mode, sync_mode, clk_en_sync, int_sel, force_low,
                force_high, div_sel, in_clk, output card_clk, int_active);
endinterface

//--- inc/ucr_pkg.sv
// Purpose: shared constants for the user-card slot register bank
// Assumes: 250 MHz system clock, byte-wide register port
// Notes: offsets are register indices on the byte register port
package ucr_pkg;
   // clock figures
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned INT_CLK_HZ = 1_200_000;
   // internal card clock half period, rounded down (104 cycles)
   localparam int unsigned INT_HALF_CYC = CLK_HZ / (2 * INT_CLK_HZ);
   localparam int unsigned INT_CNT_W = 8;

   // register offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_SETTINGS = 8'h01;
   localparam logic [7:0] OFS_CLOCK = 8'h02;

   // status bit positions
   localparam int unsigned ST_ACTIVE = 7;
   localparam int unsigned ST_EARLY = 6;
   localparam int unsigned ST_MUTE = 5;
   localparam int unsigned ST_PROT = 4;
   localparam int unsigned ST_INTCLK = 3;
   localparam int unsigned ST_PRESL = 2;
   localparam int unsigned ST_PRESENCE_INPUT = 1;
   localparam int unsigned ST_VCCFAIL = 0;

   // settings field positions
   localparam int unsigned SET_VSEL_HI = 7;
   localparam int unsigned SET_VSEL_LO = 6;
   localparam int unsigned SET_IOEN = 5;
   localparam int unsigned SET_WARM = 3;
   localparam int unsigned SET_POL = 2;
   localparam int unsigned SET_ASYNC = 0;

   // clock register field positions
   localparam int unsigned CK_INT = 7;
   localparam int unsigned CK_LOW = 6;
   localparam int unsigned CK_HIGH = 5;
   localparam int unsigned CK_DIV_HI = 4;
   localparam int unsigned CK_DIV_LO = 2;

   // reset values
   localparam logic [1:0] RST_VSEL = 2'h1;
   localparam logic RST_IOEN = 1'b1;
   localparam logic [2:0] RST_DIV = 3'h3;
   // io bridge hold-off after a release, in cycles
   localparam logic [1:0] IO_HOLD_CYC = 2'h2;

   // supply voltage codes
   localparam logic [1:0] VSEL_3V = 2'h2;
   localparam logic [1:0] VSEL_5V = 2'h3;

   // io bridge ownership states
   typedef enum logic [2:0] {
      IO_IDLE = 3'b001,
      IO_HOST = 3'b010,
      IO_CARD = 3'b100
   } ucr_io_e;
endpackage

//--- sim/tb.sv
// Purpose: self-checking bench for the user-card slot registers
// Assumes: inputs change 1 ns after the rising edge
// Notes: input clock runs at one tenth of the system clock
`timescale 1ns/1ns
module tb;
   import ucr_pkg::*;
   logic clock_i = 0, reset_i = 1, wr = 0, rd = 0, act = 0, early = 0, miss = 0, ocur = 0;
   logic rfault = 0, autod = 0, wstart = 0, syncm = 0, manm = 0, cken = 0, inclk = 0;
   logic ins = 0, cpull = 0, hpull = 0, hoe, coe, wreq, sum, cclk, asy, presence_input, cio, hdo, cdo;
   logic [7:0] addr = 0, wdata = 0, rdata, d, p, m_set = 8'h60, m_clk = 8'h0c;
   logic [1:0] vsel;
   int m_flag = 0, num_errors = 0, cmp_count = 0;
   int ev_bit[4] = '{6, 5, 4, 0};
   int dv[8] = '{1, 2, 4, 5, 8, 8, 8, 8};
   wire hlvl = !(hpull || hoe);
   always #2 clock_i = ~clock_i;
   // input clock: 5 cycles high, 5 low
   always begin
      repeat (5) @(posedge clock_i);
      #1 inclk = ~inclk;
   end
   ucr_card_model i_card (.inserted_i(ins), .pull_low_i(cpull), .dut_oe_i(coe),
      .presence_o(presence_input), .io_level_o(cio));
   ucr_slot_regs i_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .slot_active_i(act), .answer_early_i(early), .answer_missing_i(miss),
      .overcurrent_i(ocur), .supply_ramp_fault_i(rfault), .auto_deactivate_i(autod),
      .warm_reset_started_i(wstart), .sync_mode_i(syncm), .manual_mode_i(manm),
      .clk_enable_sync_i(cken), .presence_input_i(presence_input), .input_clock_i(inclk),
      .host_io_line_i(hlvl), .host_io_line_o(hdo), .host_io_line_oe_o(hoe),
      .card_io_line_i(cio), .card_io_line_o(cdo), .card_io_line_oe_o(coe),
      .supply_voltage_select_o(vsel), .async_activation_o(asy),
      .warm_reset_request_o(wreq), .slot_interrupt_summary_o(sum),
      .card_clock_output_o(cclk));
   task automatic cyc(int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(logic [7:0] a, logic [7:0] v);
      addr = a;
      wdata = v;
      wr = 1;
      cyc(1);
      wr = 0;
      // strobe stays low one cycle, so back-to-back calls never glitch it
      cyc(1);
   endtask
   task automatic rd_reg(logic [7:0] a);
      addr = a;
      rd = 1;
      cyc(1);
      rd = 0;
      d = rdata;
      cyc(1);
   endtask
   // one-cycle event pulse, then one cycle for the flag to land
   task automatic pulse(int b);
      case (b)
         6: early = 1;
         5: miss = 1;
         4: ocur = 1;
         default: rfault = 1;
      endcase
      cyc(1);
      {early, miss, ocur, rfault} = 4'h0;
      cyc(1);
      m_flag |= 1 << b;
   endtask
   // rising-to-rising distance of the card clock, 0 if it never toggles
   task automatic meas();
      int t0;
      logic prev;
      t0 = -1;
      p = 0;
      for (int n = 0; n < 600 && p == 0; n++) begin
         prev = cclk;
         cyc(1);
         if (prev === 1'b0 && cclk === 1'b1) begin
            if (t0 < 0) t0 = n;
            else p = 8'(n - t0);
         end
      end
   endtask
   function automatic logic [7:0] st_exp();
      logic ic;
      ic = m_set[0] && !(syncm || manm) && m_clk[7];
      return 8'(m_flag) | {act, 3'h0, ic, 1'b0, m_set[2] ? !ins : ins, 1'b0};
   endfunction
   task automatic end_sim();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // the tests take about 3000 cycles; this allows far more
   initial begin
      #80000;
      num_errors++;
      end_sim();
   end
   initial begin
      void'($urandom(68418));
      cyc(5);
      reset_i = 0;
      rd_reg(OFS_STATUS);
      chk("status", st_exp(), d);
      rd_reg(OFS_SETTINGS);
      chk("settings", 8'h60, d);
      rd_reg(OFS_CLOCK);
      chk("clock reg", 8'h0c, d);
      rd_reg(8'h03);
      chk("unmapped", 8'h00, d);
      foreach (ev_bit[i]) begin
         pulse(ev_bit[i]);
         chk("summary", 8'h01, {7'h0, sum});
         rd_reg(OFS_STATUS);
         chk("status", st_exp(), d);
         m_flag = 0;
      end
      // event landing on the read edge must survive the read
      addr = OFS_STATUS;
      {ocur, rd} = 2'b11;
      cyc(1);
      {ocur, rd} = 2'b00;
      d = rdata;
      cyc(1);
      chk("status", st_exp(), d);
      m_flag = 'h10;
      rd_reg(OFS_STATUS);
      chk("status", st_exp(), d);
      m_flag = 0;
      chk("summary", 8'h00, {7'h0, sum});
      for (int v = 0; v < 4; v++) begin
         m_set = {v[1:0], 1'($urandom), 5'h0};
         wr_reg(OFS_SETTINGS, m_set);
         rd_reg(OFS_SETTINGS);
         chk("settings", m_set, d);
         chk("vsel", 8'(v), {6'h0, vsel});
      end
      for (int e = 1; e >= 0; e--) begin
         wr_reg(OFS_SETTINGS, 8'h40 | 8'(e << 5));
         cpull = 1;
         cyc(6);
         chk("host oe", 8'(e), {7'h0, hoe});
         cpull = 0;
         cyc(6);
         hpull = 1;
         cyc(6);
         chk("card oe", 8'(e), {7'h0, coe});
         hpull = 0;
         cyc(6);
      end
      chk("io drive", 8'h00, {6'h0, hdo, cdo});
      for (int k = 0; k < 2; k++) begin
         {syncm, manm} = k ? 2'b01 : 2'b10;
         wr_reg(OFS_SETTINGS, 8'h49);
         chk("locked bits", 8'h00, {6'h0, wreq, asy});
         rd_reg(OFS_SETTINGS);
         chk("settings", 8'h40, d);
      end
      {syncm, manm} = 2'b00;
      wr_reg(OFS_SETTINGS, 8'h49);
      chk("warm async", 8'h03, {6'h0, wreq, asy});
      wstart = 1;
      cyc(1);
      wstart = 0;
      autod = 1;
      cyc(1);
      autod = 0;
      cyc(1);
      rd_reg(OFS_SETTINGS);
      chk("settings", 8'h40, d);
      for (int pol = 0; pol < 2; pol++) begin
         m_set = 8'h40 | 8'(pol << 2);
         wr_reg(OFS_SETTINGS, m_set);
         ins = !ins;
         cyc(8);
         m_flag = 4;
         rd_reg(OFS_STATUS);
         chk("status", st_exp(), d);
         m_flag = 0;
      end
      act = 1;
      m_set = 8'h41;
      wr_reg(OFS_SETTINGS, m_set);
      wr_reg(OFS_CLOCK, 8'h40);
      meas();
      chk("low period", 8'h00, p);
      chk("card clk", 8'h00, {7'h0, cclk});
      wr_reg(OFS_CLOCK, 8'h20);
      cyc(6);
      chk("card clk", 8'h01, {7'h0, cclk});
      m_clk = 8'h80;
      wr_reg(OFS_CLOCK, m_clk);
      cyc(6);
      rd_reg(OFS_STATUS);
      chk("status", st_exp(), d);
      meas();
      chk("int period", 8'(2 * INT_HALF_CYC), p);
      for (int c = 0; c < 8; c++) begin
         wr_reg(OFS_CLOCK, 8'(c << 2));
         cyc(90);
         meas();
         chk("div period", 8'(10 * dv[c]), p);
      end
      syncm = 1;
      cken = 1;
      wr_reg(OFS_CLOCK, 8'h1c);
      cyc(10);
      meas();
      chk("sync period", 8'd10, p);
      cken = 0;
      wr_reg(OFS_CLOCK, 8'h20);
      cyc(6);
      chk("card clk", 8'h01, {7'h0, cclk});
      end_sim();
   end
endmodule

//--- sim/ucr_card_model.sv
// Purpose: user card stand-in: presence pin and open-drain io line
// Assumes: pulled-up pins, a seated card shorts presence low
// Notes: a released io line reads high through its pull-up
`timescale 1ns/1ns
module ucr_card_model (
   input wire logic inserted_i, // card seated
   input wire logic pull_low_i, // card drives io low
   input wire logic dut_oe_i, // slot drives io low
   output logic presence_o, // presence pin
   output logic io_level_o // resolved io wire
);
   // pull-ups give the idle high level
   assign presence_o = !inserted_i;
   assign io_level_o = !(pull_low_i || dut_oe_i);
endmodule

//--- sim/ucr_slot_regs_props.sv
// Purpose: bound checker for the user-card slot registers
// Assumes: one clock, synchronous active-high reset
// Notes: sees the top-level ports only
`timescale 1ns/1ns
module ucr_slot_regs_props
   import ucr_pkg::*;
(
   input wire logic clock_i, // clock
   input wire logic reset_i, // reset
   input wire logic [7:0] reg_addr_i, // index
   input wire logic reg_wr_i, // write
   input wire logic reg_rd_i, // read
   input wire logic [7:0] reg_wdata_i, // wdata
   input wire logic [7:0] reg_rdata_o, // rdata
   input wire logic slot_active_i, // active
   input wire logic answer_early_i, // early
   input wire logic answer_missing_i, // missing
   input wire logic overcurrent_i, // overcurrent
   input wire logic supply_ramp_fault_i, // ramp fault
   input wire logic auto_deactivate_i, // auto off
   input wire logic sync_mode_i, // sync
   input wire logic manual_mode_i, // manual
   input wire logic presence_input_i, // presence pin
   input wire logic [1:0] supply_voltage_select_o, // vsel
   input wire logic async_activation_o, // async bit
   input wire logic warm_reset_request_o, // warm bit
   input wire logic slot_interrupt_summary_o, // summary
   input wire logic card_clock_output_o // card clock
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   wire wr_set = reg_wr_i && reg_addr_i == OFS_SETTINGS;
   wire rd_st = reg_rd_i && reg_addr_i == OFS_STATUS;
   wire lock = sync_mode_i || manual_mode_i;
   wire no_ev = !(answer_early_i || answer_missing_i || overcurrent_i || supply_ramp_fault_i);
   logic [4:0] presence_input_h;
   // pin history: a pin edge lands in the change flag a few cycles late
   always_ff @(posedge clock_i) begin
      presence_input_h <= {presence_input_h[3:0], presence_input_i};
   end
   wire presence_input_quiet = (presence_input_h == 5'h00 || presence_input_h == 5'h1f) && presence_input_i == presence_input_h[0];
   sequence s_low_wr;
      reg_wr_i && reg_addr_i == OFS_CLOCK && reg_wdata_i[7:6] == 2'h1;
   endsequence
   sequence s_no_clk_wr;
      !(reg_wr_i && reg_addr_i == OFS_CLOCK) [*6];
   endsequence
   AST_ACTIVE: assert property (rd_st |=> reg_rdata_o[7] == $past(slot_active_i))
      else $error("active bit wrong");
   AST_EARLY: assert property (answer_early_i |=> slot_interrupt_summary_o)
      else $error("early event lost");
   AST_OVERCUR: assert property (overcurrent_i |=> slot_interrupt_summary_o)
      else $error("overcurrent event lost");
   AST_VSEL: assert property (wr_set |=>
      supply_voltage_select_o == $past(reg_wdata_i[7:6]))
      else $error("supply select wrong");
   AST_WARM: assert property (wr_set && reg_wdata_i[3] && !lock |=> warm_reset_request_o)
      else $error("warm reset not taken");
   AST_WARM_LOCK: assert property (wr_set && lock && !warm_reset_request_o |=>
      !warm_reset_request_o)
      else $error("warm reset taken while locked");
   AST_ASYNC: assert property (wr_set && !lock |=>
      async_activation_o == $past(reg_wdata_i[0]))
      else $error("activation bit wrong");
   AST_AUTO: assert property (auto_deactivate_i && !(wr_set && !lock) |=>
      !async_activation_o)
      else $error("activation bit kept after auto off");
   AST_CLK_LOW: assert property (s_low_wr ##1 s_no_clk_wr |-> !card_clock_output_o)
      else $error("card clock not held low");
   AST_RD_CLEAR: assert property (rd_st && presence_input_quiet && no_ev |=>
      !slot_interrupt_summary_o)
      else $error("flags not cleared by read");
endmodule
bind ucr_slot_regs ucr_slot_regs_props i_props (.*);
